/* hdl/serial_bus_mode_control.sv */
// mode, size, divider and command logic of the serial bus interface
// assumes a classic wishbone master and a shifter engine on core_clk
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
module serial_bus_mode_control
    import serial_bus_mode_control_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [DATA_W-1:0]   wb_dat_i,
    output logic      [DATA_W-1:0]   wb_dat_o,
    output logic                     wb_ack_o,
    // engine status
    input  wire logic                serialEvent,
    input  wire logic                busBusy,
    input  wire logic [3:0]          engineFlags,
    // engine control
    output logic                     masterSelect,
    output logic                     directionSelect,
    output logic                     startRequest,
    output logic                     stopRequest,
    output logic      [1:0]          operatingMode,
    output logic                     pinsEnabled,
    output logic                     softResetActive,
    output logic      [3:0]          dataLength,
    output logic      [3:0]          clockCount,
    output logic                     ackEnable,
    output logic                     sclTick,
    // interrupts
    output logic                     serialInterrupt,
    output logic                     irq
);
    logic [2:0]         transferSize_reg;
    logic               ack_reg;
    logic [2:0]         freqSelect_reg;
    logic               serialPending_reg;
    logic [1:0]         mode_reg;
    soft_reset_type     srState_reg;
    logic [3:0]         srCount_reg;
    logic [IRQ_W-1:0]   irqStatus_reg;
    logic [IRQ_W-1:0]   irqEnable_reg;
    logic [11:0]        divCount_reg;
    logic [11:0]        divPeriod;
    logic [3:0]         freqN;
    logic               softResetMonitor;
    logic               resetDone;
    logic               busReq;
    logic               wrStrobe;
    logic               wrTransfer;
    logic               wrCommand;
    logic               wrClear;
    logic               wrEnable;
    logic [7:0]         transferRead;
    logic [7:0]         statusRead;
    logic [DATA_W-1:0]  readData;
    logic               srStart;
    logic [1:0]         cmdMode;

    // bus decode; only byte lane 0 carries register bits
    assign busReq     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrStrobe   = busReq && wb_we_i && wb_sel_i[0];
    assign wrTransfer = wrStrobe && (wb_adr_i == TRANSFER_CTRL_OFS);
    assign wrCommand  = wrStrobe && (wb_adr_i == BUS_COMMAND_OFS);
    assign wrClear    = wrStrobe && (wb_adr_i == IRQ_CLEAR_OFS);
    assign wrEnable   = wrStrobe && (wb_adr_i == IRQ_ENABLE_OFS);

    // mode a command write leaves behind; a key forces bus mode
    assign cmdMode = (wb_dat_i[SWRST_MSB:SWRST_LSB] != SWRST_NONE)
                     ? MODE_BUS : wb_dat_i[MODE_MSB:MODE_LSB];
    // second key write; used to mute a tick launched on that edge
    assign srStart = wrCommand && srState_reg == SR_ARMED
                     && wb_dat_i[SWRST_MSB:SWRST_LSB] == SWRST_SECOND;

    // one wait state; ack falls the cycle after it was given
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    // transfer size, acknowledge and frequency settings
    always_ff @(posedge core_clk) begin
        if (rst) begin
            transferSize_reg <= SIZE_EIGHT_CODE;
            ack_reg          <= 1'b0;
            freqSelect_reg   <= 3'h0;
        end else if (wrTransfer) begin
            transferSize_reg <= wb_dat_i[SIZE_MSB:SIZE_LSB];
            ack_reg          <= wb_dat_i[ACK_BIT];
            freqSelect_reg   <= wb_dat_i[FREQ_MSB:FREQ0_BIT];
        end
    end

    // data length and clock count per transfer
    always_comb begin
        if (transferSize_reg == SIZE_EIGHT_CODE) begin
            dataLength = DATA_LEN_MAX;
        end else begin
            dataLength = {1'b0, transferSize_reg};
        end
        clockCount = dataLength + {3'h0, ack_reg};
    end
    assign ackEnable = ack_reg;

    // scl divider; reserved code stops the tick rather than guess a rate
    assign freqN     = FREQ_N_BASE + {1'b0, freqSelect_reg};
    assign divPeriod = (FREQ_ONE << freqN) + FREQ_OFFSET;

    always_ff @(posedge core_clk) begin
        if (rst || softResetActive || mode_reg == MODE_PORT
            || freqSelect_reg == FREQ_RESERVED) begin
            divCount_reg <= 12'h000;
        end else if (divCount_reg >= divPeriod - FREQ_ONE) begin
            divCount_reg <= 12'h000;
        end else begin
            divCount_reg <= divCount_reg + FREQ_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclTick <= 1'b0;
        end else begin
            sclTick <= !softResetActive && !srStart
                       && mode_reg != MODE_PORT
                       && freqSelect_reg != FREQ_RESERVED
                       && divCount_reg >= divPeriod - FREQ_ONE;
        end
    end

    // operating mode; any nonzero value in the key field forces bus mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= MODE_PORT;
        end else if (wrCommand) begin
            if (wb_dat_i[SWRST_MSB:SWRST_LSB] != SWRST_NONE) begin
                mode_reg <= MODE_BUS;
            end else begin
                mode_reg <= wb_dat_i[MODE_MSB:MODE_LSB];
            end
        end
    end
    assign operatingMode = mode_reg;
    assign pinsEnabled   = (mode_reg == MODE_SERIAL)
                           || (mode_reg == MODE_BUS);

    // master and direction selects; a soft reset returns slave receive
    always_ff @(posedge core_clk) begin
        if (rst || softResetActive) begin
            masterSelect    <= 1'b0;
            directionSelect <= 1'b0;
        end else if (wrCommand) begin
            masterSelect    <= wb_dat_i[MASTER_BIT];
            directionSelect <= wb_dat_i[DIR_BIT];
        end
    end

    // start and stop pulses, only a master in bus mode drives conditions
    always_ff @(posedge core_clk) begin
        if (rst) begin
            startRequest <= 1'b0;
            stopRequest  <= 1'b0;
        end else begin
            startRequest <= wrCommand && wb_dat_i[MASTER_BIT]
                            && wb_dat_i[COND_BIT]
                            && mode_reg == MODE_BUS
                            && cmdMode == MODE_BUS
                            && !softResetActive;
            stopRequest  <= wrCommand && wb_dat_i[MASTER_BIT]
                            && !wb_dat_i[COND_BIT]
                            && mode_reg == MODE_BUS
                            && cmdMode == MODE_BUS
                            && !softResetActive;
        end
    end

    // pending serial interrupt; a new event wins over a clear
    always_ff @(posedge core_clk) begin
        if (rst || softResetActive) begin
            serialPending_reg <= 1'b0;
        end else if (serialEvent) begin
            serialPending_reg <= 1'b1;
        end else if (wrCommand && wb_dat_i[PIN_BIT]) begin
            serialPending_reg <= 1'b0;
        end
    end
    assign serialInterrupt = serialPending_reg;

    // two-step soft reset key, any other command write except a repeated first key disarms it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srState_reg <= SR_IDLE;
            srCount_reg <= 4'h0;
        end else begin
            case (srState_reg)
                SR_IDLE: begin
                    if (wrCommand && wb_dat_i[SWRST_MSB:SWRST_LSB]
                        == SWRST_FIRST) begin
                        srState_reg <= SR_ARMED;
                    end
                end
                SR_ARMED: begin
                    if (wrCommand) begin
                        if (wb_dat_i[SWRST_MSB:SWRST_LSB]
                            == SWRST_SECOND) begin
                            srState_reg <= SR_ACTIVE;
                            srCount_reg <= SOFT_RESET_CYCLES;
                        end else if (wb_dat_i[SWRST_MSB:SWRST_LSB]
                                     != SWRST_FIRST) begin
                            srState_reg <= SR_IDLE;
                        end
                    end
                end
                SR_ACTIVE: begin
                    srCount_reg <= srCount_reg - 4'h1;
                    if (srCount_reg == 4'h1) begin
                        srState_reg <= SR_IDLE;
                    end
                end
                default: begin
                    srState_reg <= SR_IDLE;
                end
            endcase
        end
    end
    assign softResetActive  = (srState_reg == SR_ACTIVE);
    assign softResetMonitor = !softResetActive;
    assign resetDone        = softResetActive && srCount_reg == 4'h1;

    // sticky interrupt status; set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStatus_reg <= '0;
        end else begin
            irqStatus_reg <= (irqStatus_reg
                              & ~(wrClear ? wb_dat_i[IRQ_W-1:0] : '0))
                             | {resetDone, serialEvent};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqEnable_reg <= '0;
        end else if (wrEnable) begin
            irqEnable_reg <= wb_dat_i[IRQ_W-1:0];
        end
    end
    assign irq = |(irqStatus_reg & irqEnable_reg);

    // read views; bit 0 shows the monitor except in serial mode
    always_comb begin
        transferRead                    = 8'h00;
        transferRead[SIZE_MSB:SIZE_LSB] = transferSize_reg;
        transferRead[ACK_BIT]           = ack_reg;
        transferRead[FIXED_ONE_BIT]     = 1'b1;
        transferRead[FREQ_MSB:FREQ_MID] = freqSelect_reg[FREQ_MSB:FREQ_MID];
        transferRead[FREQ0_BIT]         = (mode_reg == MODE_SERIAL)
                                          ? freqSelect_reg[FREQ0_BIT]
                                          : softResetMonitor;
        statusRead                      = {4'h0, engineFlags};
        statusRead[MASTER_BIT]          = masterSelect;
        statusRead[DIR_BIT]             = directionSelect;
        statusRead[COND_BIT]            = busBusy;
        statusRead[PIN_BIT]             = !serialPending_reg;
        case (wb_adr_i)
            TRANSFER_CTRL_OFS: readData = {24'h000000, transferRead};
            BUS_COMMAND_OFS:   readData = {24'h000000, statusRead};
            IRQ_STATUS_OFS:    readData = {30'h00000000, irqStatus_reg};
            IRQ_ENABLE_OFS:    readData = {30'h00000000, irqEnable_reg};
            default:           readData = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (busReq && !wb_we_i) begin
            wb_dat_o <= readData;
        end
    end
endmodule : serial_bus_mode_control

/* inc/serial_bus_mode_control_pkg.sv */
// constants for the serial bus mode control block
// assumes a 32-bit classic wishbone slave with byte addresses
package serial_bus_mode_control_pkg;
    localparam int           ADDR_W            = 8;
    localparam int           DATA_W            = 32;
    localparam int           CLK_HZ            = 40000000;
    // register byte offsets
    localparam logic [7:0]   TRANSFER_CTRL_OFS = 8'h04;
    localparam logic [7:0]   BUS_COMMAND_OFS   = 8'h10;
    localparam logic [7:0]   IRQ_STATUS_OFS    = 8'h20;
    localparam logic [7:0]   IRQ_CLEAR_OFS     = 8'h24;
    localparam logic [7:0]   IRQ_ENABLE_OFS    = 8'h28;
    // transfer_control fields
    localparam int           SIZE_MSB          = 7;
    localparam int           SIZE_LSB          = 5;
    localparam int           ACK_BIT           = 4;
    localparam int           FIXED_ONE_BIT     = 3;
    localparam int           FREQ_MSB          = 2;
    localparam int           FREQ_MID          = 1;
    localparam int           FREQ0_BIT         = 0;
    // bus_command / bus_status fields
    localparam int           MASTER_BIT        = 7;
    localparam int           DIR_BIT           = 6;
    localparam int           COND_BIT          = 5;
    localparam int           PIN_BIT           = 4;
    localparam int           MODE_MSB          = 3;
    localparam int           MODE_LSB          = 2;
    localparam int           SWRST_MSB         = 1;
    localparam int           SWRST_LSB         = 0;
    // operating modes
    localparam logic [1:0]   MODE_PORT         = 2'h0;
    localparam logic [1:0]   MODE_SERIAL       = 2'h1;
    localparam logic [1:0]   MODE_BUS          = 2'h2;
    // soft reset key
    localparam logic [1:0]   SWRST_NONE        = 2'h0;
    localparam logic [1:0]   SWRST_FIRST       = 2'h2;
    localparam logic [1:0]   SWRST_SECOND      = 2'h1;
    localparam logic [3:0]   SOFT_RESET_CYCLES = 4'h4;
    // transfer size
    localparam logic [2:0]   SIZE_EIGHT_CODE   = 3'h0;
    localparam logic [3:0]   DATA_LEN_MAX      = 4'h8;
    // scl divider: period = 2^(code+5) + 72 system clocks
    localparam logic [3:0]   FREQ_N_BASE       = 4'h5;
    localparam logic [11:0]  FREQ_OFFSET       = 12'h048;
    localparam logic [11:0]  FREQ_ONE          = 12'h001;
    localparam logic [2:0]   FREQ_RESERVED     = 3'h7;
    // interrupt status bits
    localparam int           IRQ_W             = 2;
    localparam int           IRQ_SERIAL        = 0;
    localparam int           IRQ_RESET_DONE    = 1;

    typedef enum logic [1:0] {
        SR_IDLE,
        SR_ARMED,
        SR_ACTIVE
    } soft_reset_type;
endpackage : serial_bus_mode_control_pkg

/* sim/serial_bus_mode_control_properties.sv */
// assertion checker for the serial bus mode control block
// assumes it is bound onto the top module, one core_clk domain
`timescale 1ns/1ps
module serial_bus_mode_control_properties
    import serial_bus_mode_control_pkg::*;
(
    // clock, reset, bus and event
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       wb_ack_o,
    input wire logic       serialEvent,
    // engine control
    input wire logic       masterSelect,
    input wire logic       startRequest,
    input wire logic       stopRequest,
    input wire logic [1:0] operatingMode,
    input wire logic       pinsEnabled,
    input wire logic       softResetActive,
    input wire logic [3:0] dataLength,
    input wire logic [3:0] clockCount,
    input wire logic       ackEnable,
    input wire logic       sclTick,
    input wire logic       serialInterrupt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_count_adds_ack: assert property (
        clockCount == dataLength + ackEnable) else $error("clock count");
    a_length_in_range: assert property (
        dataLength != 4'h0 && dataLength <= 4'h8) else $error("data length");
    a_pins_by_mode: assert property (pinsEnabled ==
        (operatingMode == MODE_SERIAL || operatingMode == MODE_BUS))
        else $error("pin enable does not follow mode");
    a_start_as_master: assert property (
        (startRequest || stopRequest) |-> masterSelect &&
        operatingMode == MODE_BUS) else $error("condition outside master");
    a_start_single: assert property (
        startRequest |=> !startRequest) else $error("start pulse too long");
    a_reset_four: assert property (
        $rose(softResetActive) |-> softResetActive[*4] ##1 !softResetActive)
        else $error("soft reset length");
    a_reset_bus_mode: assert property (
        softResetActive |-> operatingMode == MODE_BUS)
        else $error("soft reset outside bus mode");
    a_reset_stops_tick: assert property (
        softResetActive |-> !sclTick) else $error("tick during soft reset");
    a_event_pending: assert property (
        serialEvent |=> serialInterrupt) else $error("event not pending");
    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule : serial_bus_mode_control_properties

bind serial_bus_mode_control serial_bus_mode_control_properties chk (
    .core_clk(core_clk), .rst(rst), .wb_ack_o(wb_ack_o),
    .serialEvent(serialEvent), .masterSelect(masterSelect),
    .startRequest(startRequest), .stopRequest(stopRequest),
    .operatingMode(operatingMode), .pinsEnabled(pinsEnabled),
    .softResetActive(softResetActive), .dataLength(dataLength),
    .clockCount(clockCount), .ackEnable(ackEnable), .sclTick(sclTick),
    .serialInterrupt(serialInterrupt)
);

/* sim/engine_model.sv */
// far side stand-in: event pulses, bus busy level and flags
// assumes the bench raises fire for one core_clk cycle
`timescale 1ns/1ps
module engine_model (
    // clock and bench control
    input  wire logic       core_clk,
    input  wire logic       fire,
    input  wire logic       busy,
    // status toward the block
    output logic            serialEvent,
    output logic            busBusy,
    output logic      [3:0] engineFlags
);
    // registered so every change lands just after an edge
    always @(posedge core_clk) begin
        serialEvent <= fire;
        busBusy     <= busy;
        engineFlags <= 4'hA;
    end
endmodule : engine_model

/* sim/serial_bus_mode_control_tb.sv */
// self-checking bench for the serial bus mode control block
// assumes classic wishbone access and the engine model on the far side
`timescale 1ns/1ps
module serial_bus_mode_control_tb import serial_bus_mode_control_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, busy = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, serialEvent, busBusy, masterSelect, directionSelect;
    logic        startRequest, stopRequest, pinsEnabled, softResetActive;
    logic        ackEnable, sclTick, serialInterrupt, irq;
    logic [3:0]  engineFlags, dataLength, clockCount;
    logic [1:0]  operatingMode;
    int          nErrors = 0, checksDone = 0, nStart = 0, nStop = 0;
    int          nSoft = 0, nTick = 0, i, base;

    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (startRequest === 1'b1) nStart <= nStart + 1;
        if (stopRequest === 1'b1) nStop <= nStop + 1;
        if (softResetActive === 1'b1) nSoft <= nSoft + 1;
        if (sclTick === 1'b1) nTick <= nTick + 1;
    end

    serial_bus_mode_control dut (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .serialEvent(serialEvent),
        .busBusy(busBusy), .engineFlags(engineFlags),
        .masterSelect(masterSelect), .directionSelect(directionSelect),
        .startRequest(startRequest), .stopRequest(stopRequest),
        .operatingMode(operatingMode), .pinsEnabled(pinsEnabled),
        .softResetActive(softResetActive), .dataLength(dataLength),
        .clockCount(clockCount), .ackEnable(ackEnable), .sclTick(sclTick),
        .serialInterrupt(serialInterrupt), .irq(irq));
    engine_model eng (.core_clk(core_clk), .fire(fire), .busy(busy),
        .serialEvent(serialEvent), .busBusy(busBusy),
        .engineFlags(engineFlags));

    task automatic results();
        if (nErrors == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic abort();
        nErrors++;
        $display("CHECK FAILED %0t wait ran out", $time);
        results();
    endtask : abort

    // request held until ack is sampled; released right after that edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge core_clk);
        if (ack !== 1'b1) abort();
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd

    // gap between the second and third tick, so a restart cannot skew it
    task automatic gap(input int want);
        int n, k, g;
        k = 0;
        g = 0;
        for (n = 0; n < 7000 && k < 3; n++) begin
            @(posedge core_clk);
            g++;
            if (sclTick === 1'b1) begin
                k++;
                if (k < 3) g = 0;
            end
        end
        if (k < 3) abort();
        check(g, want);
    endtask : gap

    task automatic pulse();
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(dataLength, 8);
        check(operatingMode, MODE_PORT);
        rd(TRANSFER_CTRL_OFS, 32'h09);
        for (i = 0; i < 16; i++) begin
            wr(TRANSFER_CTRL_OFS, 32'(i << 4));
            base = (i / 2 == 0) ? 8 : i / 2;
            check(dataLength, base);
            check(clockCount, base + i % 2);
            rd(TRANSFER_CTRL_OFS, 32'(i << 4) | 32'h09);
        end
        wr(TRANSFER_CTRL_OFS, 32'h0); // size cleared first
        for (i = 0; i < 4; i++) begin
            wr(BUS_COMMAND_OFS, 32'(i << 2)); // idle pins
            check(operatingMode, i);
            check(pinsEnabled, i == 1 || i == 2);
            if (i == 1) rd(TRANSFER_CTRL_OFS, 32'h08);
        end
        wr(BUS_COMMAND_OFS, 32'h08); // no transfer running
        gap(104);
        for (i = 1; i < 7; i++) begin
            wr(TRANSFER_CTRL_OFS, 32'(i));
            gap((1 << (i + 5)) + 72);
        end
        wr(TRANSFER_CTRL_OFS, 32'h7);
        base = nTick;
        repeat (300) @(posedge core_clk);
        check(nTick - base, 0);
        wr(TRANSFER_CTRL_OFS, 32'h0); // size 8 before any stop
        base = nStart;
        wr(BUS_COMMAND_OFS, 32'hE8);
        rd(BUS_COMMAND_OFS, 32'hDA);
        check(nStart - base, 1);
        check(directionSelect, 1);
        base = nStop;
        wr(BUS_COMMAND_OFS, 32'hC8);
        busy <= 1'b1;
        rd(BUS_COMMAND_OFS, 32'hFA);
        check(nStop - base, 1);
        base = nStart;
        wr(BUS_COMMAND_OFS, 32'h28);
        busy <= 1'b0;
        rd(BUS_COMMAND_OFS, 32'h1A);
        check(nStart - base, 0);
        pulse();
        check(serialInterrupt, 1);
        rd(IRQ_STATUS_OFS, 32'h1);
        rd(BUS_COMMAND_OFS, 32'h0A);
        wr(IRQ_ENABLE_OFS, 32'h1);
        check(irq, 1);
        wr(IRQ_ENABLE_OFS, 32'h0);
        check(irq, 0);
        wr(IRQ_CLEAR_OFS, 32'h1);
        wr(IRQ_STATUS_OFS, 32'h3);
        rd(IRQ_STATUS_OFS, 32'h0);
        rd(8'h3C, 32'h0);
        pulse();
        wr(BUS_COMMAND_OFS, 32'h08);
        check(serialInterrupt, 1);
        wr(BUS_COMMAND_OFS, 32'h18);
        check(serialInterrupt, 0);
        pulse();
        base = nSoft;
        wr(BUS_COMMAND_OFS, 32'h06);
        check(nSoft - base, 0);
        wr(BUS_COMMAND_OFS, 32'h01);
        rd(TRANSFER_CTRL_OFS, 32'h08); // monitor low mid reset
        repeat (6) @(posedge core_clk);
        check(nSoft - base, 4);
        check(serialInterrupt, 0);
        bus(1'b0, IRQ_STATUS_OFS, 32'h0, q);
        check(q[1], 1);
        rd(TRANSFER_CTRL_OFS, 32'h09);
        wr(BUS_COMMAND_OFS, 32'h00);
        wr(BUS_COMMAND_OFS, 32'h01);
        check(operatingMode, MODE_BUS);
        repeat (6) @(posedge core_clk);
        check(nSoft - base, 4);
        results();
    end
endmodule : serial_bus_mode_control_tb
